/* hdl/acr_pkg.sv */
package acr_pkg;
  // reset pin timing, in master clock cycles
  localparam int unsigned RST_MIN_CYC = 4;
  localparam int unsigned PD_CYC_DEF = 65536;
  localparam int unsigned RST_CMD_GAP_CYC = 8;
  localparam int unsigned PD_EXIT_GAP_CYC = 65536;
  // chop settling after each polarity reversal
  localparam logic [8:0] FILTER_SETTLE_CYC = 9'h010;
  localparam logic [4:0] SETTLE_UNIT_CYC = 5'h10;
  // opcodes with the low bit ignored
  localparam logic [6:0] OPC_RESET_HI = 7'h03;
  localparam logic [6:0] OPC_PRI_BEGIN_HI = 7'h04;
  localparam logic [6:0] OPC_PRI_HALT_HI = 7'h05;
  localparam logic [6:0] OPC_AUX_BEGIN_HI = 7'h06;
  localparam logic [6:0] OPC_AUX_HALT_HI = 7'h07;
  localparam logic [6:0] OPC_PRI_READ_HI = 7'h09;
  localparam logic [6:0] OPC_AUX_READ_HI = 7'h0A;
  // full-byte opcodes
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_PRI_SYS_OFS = 8'h16;
  localparam logic [7:0] OPC_PRI_SYS_GAIN = 8'h17;
  localparam logic [7:0] OPC_PRI_SELF_OFS = 8'h19;
  localparam logic [7:0] OPC_AUX_SYS_OFS = 8'h1B;
  localparam logic [7:0] OPC_AUX_SYS_GAIN = 8'h1C;
  localparam logic [7:0] OPC_AUX_SELF_OFS = 8'h1E;
  // two-byte prefixes and field layout
  localparam logic [2:0] PFX_REG_READ = 3'h1;
  localparam logic [2:0] PFX_REG_WRITE = 3'h2;
  localparam logic [2:0] PFX_COUNT = 3'h0;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned PRI_W = 32;
  localparam int unsigned AUX_W = 24;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // decoded command codes
  typedef enum logic [4:0] {
    CMD_NONE, CMD_NOP, CMD_RESET, CMD_PRI_BEGIN, CMD_PRI_HALT,
    CMD_AUX_BEGIN, CMD_AUX_HALT, CMD_PRI_READ, CMD_AUX_READ,
    CMD_PRI_SYS_OFS, CMD_PRI_SYS_GAIN, CMD_PRI_SELF_OFS,
    CMD_AUX_SYS_OFS, CMD_AUX_SYS_GAIN, CMD_AUX_SELF_OFS,
    CMD_REG_READ, CMD_REG_WRITE
  } acr_cmd_t;

  // serial interface states
  typedef enum logic [1:0] {ST_OPC, ST_OPC2, ST_REG} acr_state_t;
endpackage

/* hdl/acr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_top
  import acr_pkg::*;
#(
  parameter int unsigned PD_CYC = acr_pkg::PD_CYC_DEF
)
(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  // device pins
  input wire logic RESET_POWERDOWN_PIN_N_IN,
  input wire logic CS_N_IN,
  input wire logic SCLK_IN,
  input wire logic DIN_IN,
  output logic DOUT_OUT,
  // command and reset status
  output acr_pkg::acr_cmd_t CMD_CODE_OUT,
  output logic CMD_STB_OUT,
  output logic PRIMARY_RUN_OUT,
  output logic AUXILIARY_RUN_OUT,
  output logic POWER_DOWN_OUT,
  output logic DEVICE_RESET_OUT,
  output logic RESET_FLAG_OUT,
  input wire logic RESET_FLAG_CLR_IN,
  // register file access
  output logic [acr_pkg::ADDR_W-1:0] REG_ADDR_OUT,
  output logic REG_RD_STB_OUT,
  input wire logic [7:0] REG_RDATA_IN,
  output logic REG_WR_STB_OUT,
  output logic [7:0] REG_WDATA_OUT,
  // primary converter and chop
  input wire logic CHOP_EN_IN,
  input wire logic [3:0] SETTLE_DELAY_IN,
  input wire logic PRI_CONV_VALID_IN,
  input wire logic [acr_pkg::PRI_W-1:0] PRI_CONV_DATA_IN,
  output logic PRI_POLARITY_OUT,
  output logic PRI_SETTLING_OUT,
  output logic PRI_RESULT_VALID_OUT,
  output logic [acr_pkg::PRI_W-1:0] PRI_RESULT_OUT,
  // auxiliary converter
  input wire logic AUX_CONV_VALID_IN,
  input wire logic [acr_pkg::AUX_W-1:0] AUX_CONV_DATA_IN
);
  import acr_pkg::*;

  logic [3:0] sync1_ff, sync2_ff;
  logic edge_ff;
  logic pin_low, cs_high, sclk_rise, sclk_fall, din_s;
  logic [31:0] low_cnt_ff;
  logic pin_rst_ff, pd_ff, cmd_rst_ff, flag_ff, int_rst;
  acr_state_t st_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] rx_ff;
  logic [7:0] rx_byte;
  logic byte_done, opc_done, is_reg_pfx, is_wr_ff;
  acr_cmd_t cmd_now, cmd_ff;
  logic cmd_stb_ff, pri_run_ff, aux_run_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [5:0] rem_ff;
  logic rd_req_ff, wr_stb_ff, enter_rd, next_rd;
  logic [7:0] wdata_ff;
  logic [PRI_W-1:0] tx_ff, pri_data_ff;
  logic [AUX_W-1:0] aux_data_ff;
  logic dout_ff, auto_load, pri_new_ff;
  logic chop_first_ff, pol_ff;
  logic [8:0] settle_ff;
  logic pri_acc;
  logic [PRI_W-1:0] prev_ff, res_ff;
  logic [PRI_W:0] chop_diff;
  logic res_vld_ff;

  // two-flop synchronisers for pin inputs
  always_ff @(posedge CORE_CLK_IN)
  begin
    sync1_ff <= {RESET_POWERDOWN_PIN_N_IN, CS_N_IN, SCLK_IN, DIN_IN};
    sync2_ff <= sync1_ff;
    edge_ff <= sync2_ff[1];
  end

  // pin level and edge decode
  assign pin_low = ~sync2_ff[3];
  assign cs_high = sync2_ff[2];
  assign sclk_rise = sync2_ff[1] & ~edge_ff;
  assign sclk_fall = ~sync2_ff[1] & edge_ff;
  assign din_s = sync2_ff[0];

  // pin low-time counter, saturating at the power-down count
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN || !pin_low)
      low_cnt_ff <= 32'h0;
    else if (low_cnt_ff < PD_CYC)
      low_cnt_ff <= low_cnt_ff + 32'h1;
  end

  // pin reset after the minimum hold, power-down after the long one
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN)
    begin
      pin_rst_ff <= 1'b0;
      pd_ff <= 1'b0;
    end
    else
    begin
      pin_rst_ff <= pin_low && (low_cnt_ff >= RST_MIN_CYC - 1);
      pd_ff <= pin_low && (low_cnt_ff >= PD_CYC - 1);
    end
  end

  // device held in reset through power-down, so its exit resets too
  assign int_rst = SRST_IN | pin_rst_ff | cmd_rst_ff;

  // reset flag: any reset sets it, set wins over software clear
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (SRST_IN || pin_rst_ff || cmd_rst_ff)
      flag_ff <= 1'b1;
    else if (RESET_FLAG_CLR_IN)
      flag_ff <= 1'b0;
  end

  // opcode decode of the byte just completed
  assign rx_byte = {rx_ff, din_s};
  assign byte_done = sclk_fall && !cs_high && (bit_cnt_ff == LAST_BIT);
  assign opc_done = byte_done && (st_ff == ST_OPC);
  assign is_reg_pfx = (rx_byte[7:5] == PFX_REG_READ) ||
                      (rx_byte[7:5] == PFX_REG_WRITE);
  assign cmd_now =
    (rx_byte == OPC_NOP) ? CMD_NOP :
    (rx_byte[7:1] == OPC_RESET_HI) ? CMD_RESET :
    (rx_byte[7:1] == OPC_PRI_BEGIN_HI) ? CMD_PRI_BEGIN :
    (rx_byte[7:1] == OPC_PRI_HALT_HI) ? CMD_PRI_HALT :
    (rx_byte[7:1] == OPC_AUX_BEGIN_HI) ? CMD_AUX_BEGIN :
    (rx_byte[7:1] == OPC_AUX_HALT_HI) ? CMD_AUX_HALT :
    (rx_byte[7:1] == OPC_PRI_READ_HI) ? CMD_PRI_READ :
    (rx_byte[7:1] == OPC_AUX_READ_HI) ? CMD_AUX_READ :
    (rx_byte == OPC_PRI_SYS_OFS) ? CMD_PRI_SYS_OFS :
    (rx_byte == OPC_PRI_SYS_GAIN) ? CMD_PRI_SYS_GAIN :
    (rx_byte == OPC_PRI_SELF_OFS) ? CMD_PRI_SELF_OFS :
    (rx_byte == OPC_AUX_SYS_OFS) ? CMD_AUX_SYS_OFS :
    (rx_byte == OPC_AUX_SYS_GAIN) ? CMD_AUX_SYS_GAIN :
    (rx_byte == OPC_AUX_SELF_OFS) ? CMD_AUX_SELF_OFS :
    (rx_byte[7:5] == PFX_REG_READ) ? CMD_REG_READ :
    (rx_byte[7:5] == PFX_REG_WRITE) ? CMD_REG_WRITE : CMD_NONE;

  // register data phase requests
  assign enter_rd = byte_done && (st_ff == ST_OPC2) && !is_wr_ff &&
                    (rx_byte[7:5] == PFX_COUNT);
  assign next_rd = byte_done && (st_ff == ST_REG) && !is_wr_ff &&
                   (rem_ff > 6'h1);

  // bit counter and receive shifter; chip select high aborts
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (int_rst || cs_high)
    begin
      bit_cnt_ff <= 3'h0;
      rx_ff <= 7'h0;
    end
    else if (sclk_fall)
    begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      rx_ff <= rx_byte[6:0];
    end
  end

  // command state machine
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (int_rst || cs_high)
      st_ff <= ST_OPC;
    else if (byte_done)
    begin
      case (st_ff)
        ST_OPC:
          if (is_reg_pfx)
            st_ff <= ST_OPC2;
        ST_OPC2:
          st_ff <= (rx_byte[7:5] == PFX_COUNT) ? ST_REG : ST_OPC;
        ST_REG:
          if (rem_ff == 6'h1)
            st_ff <= ST_OPC;
        default:
          st_ff <= ST_OPC;
      endcase
    end
  end

  // register address, byte count and strobes
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (int_rst)
    begin
      addr_ff <= '0;
      rem_ff <= 6'h0;
      is_wr_ff <= 1'b0;
      wdata_ff <= 8'h0;
      wr_stb_ff <= 1'b0;
      rd_req_ff <= 1'b0;
    end
    else
    begin
      rd_req_ff <= enter_rd || next_rd;
      wr_stb_ff <= byte_done && (st_ff == ST_REG) && is_wr_ff;
      if (opc_done && is_reg_pfx)
      begin
        addr_ff <= rx_byte[ADDR_W-1:0];
        is_wr_ff <= (rx_byte[7:5] == PFX_REG_WRITE);
      end
      else if (byte_done && (st_ff == ST_OPC2))
        rem_ff <= {1'b0, rx_byte[4:0]} + 6'h1;
      else if (byte_done && (st_ff == ST_REG))
      begin
        wdata_ff <= rx_byte;
        rem_ff <= rem_ff - 6'h1;
      end
      if (rd_req_ff || wr_stb_ff)
        addr_ff <= addr_ff + 5'h1;
    end
  end

  // command pulse, converter run state and command reset
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (int_rst)
    begin
      cmd_ff <= CMD_NONE;
      cmd_stb_ff <= 1'b0;
      pri_run_ff <= 1'b0;
      aux_run_ff <= 1'b0;
      cmd_rst_ff <= 1'b0;
    end
    else
    begin
      cmd_stb_ff <= opc_done && (cmd_now != CMD_NONE);
      cmd_ff <= opc_done ? cmd_now : CMD_NONE;
      cmd_rst_ff <= opc_done && (cmd_now == CMD_RESET);
      if (cmd_stb_ff && cmd_ff == CMD_PRI_BEGIN)
        pri_run_ff <= 1'b1;
      else if (cmd_stb_ff && cmd_ff == CMD_PRI_HALT)
        pri_run_ff <= 1'b0;
      if (cmd_stb_ff && cmd_ff == CMD_AUX_BEGIN)
        aux_run_ff <= 1'b1;
      else if (cmd_stb_ff && cmd_ff == CMD_AUX_HALT)
        aux_run_ff <= 1'b0;
    end
  end

  // new results load the shifter only while no command is open
  assign auto_load = pri_new_ff && (st_ff == ST_OPC) &&
                     (bit_cnt_ff == 3'h0);

  // output shifter: new bit on each serial clock rise
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (int_rst)
    begin
      tx_ff <= '0;
      dout_ff <= 1'b0;
      pri_new_ff <= 1'b0;
    end
    else
    begin
      if (cmd_stb_ff && cmd_ff == CMD_PRI_READ)
        tx_ff <= pri_data_ff;
      else if (cmd_stb_ff && cmd_ff == CMD_AUX_READ)
        tx_ff <= {aux_data_ff, 8'h00};
      else if (rd_req_ff)
        tx_ff <= {REG_RDATA_IN, 24'h0};
      else if (auto_load)
        tx_ff <= pri_data_ff;
      else if (sclk_rise && !cs_high)
      begin
        tx_ff <= {tx_ff[PRI_W-2:0], 1'b0};
        dout_ff <= tx_ff[PRI_W-1];
      end
      if (res_vld_ff)
        pri_new_ff <= 1'b1;
      else if (auto_load || (cmd_stb_ff && cmd_ff == CMD_PRI_READ))
        pri_new_ff <= 1'b0;
    end
  end

  // chop arithmetic: sign follows the polarity of the newest sample
  assign chop_diff = pol_ff ?
    ({prev_ff[PRI_W-1], prev_ff} -
     {PRI_CONV_DATA_IN[PRI_W-1], PRI_CONV_DATA_IN}) :
    ({PRI_CONV_DATA_IN[PRI_W-1], PRI_CONV_DATA_IN} -
     {prev_ff[PRI_W-1], prev_ff});
  assign pri_acc = PRI_CONV_VALID_IN && pri_run_ff && (settle_ff == 9'h0);

  // primary result path with optional chop sequencing
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (int_rst || !pri_run_ff)
    begin
      chop_first_ff <= 1'b1;
      pol_ff <= 1'b0;
      settle_ff <= 9'h0;
      prev_ff <= '0;
      res_ff <= '0;
      res_vld_ff <= 1'b0;
    end
    else
    begin
      res_vld_ff <= pri_acc && !(CHOP_EN_IN && chop_first_ff);
      if (settle_ff != 9'h0)
        settle_ff <= settle_ff - 9'h1;
      if (pri_acc && !CHOP_EN_IN)
        res_ff <= PRI_CONV_DATA_IN;
      else if (pri_acc)
      begin
        chop_first_ff <= 1'b0;
        prev_ff <= PRI_CONV_DATA_IN;
        pol_ff <= ~pol_ff;
        settle_ff <= FILTER_SETTLE_CYC +
                     9'(SETTLE_DELAY_IN * SETTLE_UNIT_CYC);
        if (!chop_first_ff)
          res_ff <= chop_diff[PRI_W:1];
      end
    end
  end

  // latest converted words held for the read commands
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (int_rst)
    begin
      pri_data_ff <= '0;
      aux_data_ff <= '0;
    end
    else
    begin
      if (res_vld_ff)
        pri_data_ff <= res_ff;
      if (AUX_CONV_VALID_IN && aux_run_ff)
        aux_data_ff <= AUX_CONV_DATA_IN;
    end
  end

  // outputs; serial out stays driven in power-down
  assign DOUT_OUT = dout_ff;
  assign CMD_CODE_OUT = cmd_ff;
  assign CMD_STB_OUT = cmd_stb_ff;
  assign PRIMARY_RUN_OUT = pri_run_ff;
  assign AUXILIARY_RUN_OUT = aux_run_ff;
  assign POWER_DOWN_OUT = pd_ff;
  assign DEVICE_RESET_OUT = int_rst;
  assign RESET_FLAG_OUT = flag_ff;
  assign REG_ADDR_OUT = addr_ff;
  assign REG_RD_STB_OUT = rd_req_ff;
  assign REG_WR_STB_OUT = wr_stb_ff;
  assign REG_WDATA_OUT = wdata_ff;
  assign PRI_POLARITY_OUT = pol_ff;
  assign PRI_SETTLING_OUT = (settle_ff != 9'h0);
  assign PRI_RESULT_VALID_OUT = res_vld_ff;
  assign PRI_RESULT_OUT = res_ff;

  // checks on reset, decode and chop behaviour
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);

  AST_SHORT_RST: assert property (
    pin_low && low_cnt_ff == RST_MIN_CYC - 1
    |=> DEVICE_RESET_OUT && !POWER_DOWN_OUT)
    else $error("pin low four cycles gave no reset");
  AST_PD_ENTRY: assert property (
    pin_low && low_cnt_ff == PD_CYC - 1 |=> POWER_DOWN_OUT)
    else $error("long pin low did not power down");
  AST_PD_RESET: assert property (
    POWER_DOWN_OUT |-> DEVICE_RESET_OUT && $past(pin_low))
    else $error("power-down without reset or pin high");
  AST_RST_CMD: assert property (
    opc_done && rx_byte[7:1] == OPC_RESET_HI && !int_rst
    |=> DEVICE_RESET_OUT)
    else $error("reset command did not reset");
  AST_START: assert property (
    CMD_STB_OUT && CMD_CODE_OUT == CMD_PRI_BEGIN && !int_rst
    |=> PRIMARY_RUN_OUT)
    else $error("primary begin did not start");
  AST_NOP: assert property (
    CMD_STB_OUT && CMD_CODE_OUT == CMD_NOP && !int_rst
    |=> $stable(PRIMARY_RUN_OUT) && $stable(AUXILIARY_RUN_OUT))
    else $error("no-operation changed state");
  AST_NO_LOAD: assert property (
    st_ff == ST_REG && !rd_req_ff && !cmd_stb_ff && !sclk_rise && !int_rst
    |=> $stable(tx_ff))
    else $error("result loaded during register command");
  AST_CS_ABORT: assert property (
    cs_high |=> st_ff == ST_OPC && bit_cnt_ff == 3'h0)
    else $error("chip select high did not abort");
  AST_CHOP_FIRST: assert property (
    pri_acc && CHOP_EN_IN && chop_first_ff && !int_rst
    |=> !PRI_RESULT_VALID_OUT && PRI_SETTLING_OUT)
    else $error("first chop conversion not withheld");
  AST_CHOP_FLIP: assert property (
    pri_acc && CHOP_EN_IN && !int_rst
    |=> PRI_SETTLING_OUT && PRI_POLARITY_OUT != $past(PRI_POLARITY_OUT))
    else $error("chop reversal without settling");
  AST_FLAG: assert property (
    DEVICE_RESET_OUT |=> RESET_FLAG_OUT)
    else $error("reset flag not set after reset");

  COV_PD: cover property (POWER_DOWN_OUT ##1 !POWER_DOWN_OUT);
  COV_RST_CMD: cover property (CMD_STB_OUT && CMD_CODE_OUT == CMD_RESET);
  COV_CHOP: cover property (PRI_RESULT_VALID_OUT && PRI_POLARITY_OUT);
  COV_REG_WR: cover property (REG_WR_STB_OUT);
endmodule
`default_nettype wire

/* tb/acr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// serial master standing in for the host controller
module acr_host_model (
  // clock
  input wire logic clk_in,
  // serial link
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out,
  input wire logic dout_in
);
  localparam int HALF = 4; // half of a 160 ns link period

  // deselected, link clock parked low between frames
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    din_out = 1'b1;
  end

  // waits are timed in master clocks
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // select drives chip select low half a link period before each command
  task automatic select();
    @(negedge clk_in);
    cs_n_out = 1'b0;
    idle(HALF);
  endtask

  // deselect; the data line is no longer meaningful, so flip it
  task automatic deselect();
    @(negedge clk_in);
    cs_n_out = 1'b1;
    din_out = ~din_out;
    idle(HALF);
  endtask

  // one byte msb first; data read back just before the next rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge clk_in);
      sclk_out = 1'b1;
      din_out = tx[i]; // all low for the no-op
      idle(HALF);
      sclk_out = 1'b0;
      idle(HALF - 1);
      rx[i] = dout_in;
    end
  endtask
endmodule
`default_nettype wire

/* tb/test_adc_command_reset_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_adc_command_reset_control;
  import acr_pkg::*;
  localparam int unsigned PD_SIM = 64; // shortened power-down count
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pin_n = 1'b1;
  logic clr = 1'b0;
  logic chop = 1'b0;
  logic [3:0] dly = 4'h1;
  logic pvalid = 1'b0;
  logic [PRI_W-1:0] pdata = '0;
  logic avalid = 1'b0;
  logic [AUX_W-1:0] adata = '0;
  logic cs_n, sclk, din, dout, stb, pri_run, aux_run, pd, dev_rst, flag;
  logic rd_stb, wr_stb, pol, settling, res_valid;
  logic [ADDR_W-1:0] addr;
  logic [7:0] rdata, wdata, rx;
  logic [PRI_W-1:0] res, last_res, word;
  acr_cmd_t code, last_cmd;
  logic [12:0] wr_log [4];
  logic rst_seen = 1'b0;
  logic pd_seen = 1'b0;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_stb = 0;
  int n_wr = 0;
  int n_rd = 0;
  int n_res = 0;
  int set_cnt = 0;
  int last_run = 0;

  // clock and register file read data
  always #10 clk = ~clk;
  assign rdata = {3'h0, addr} ^ 8'hA5;

  acr_top #(.PD_CYC(PD_SIM)) uut (
    .CORE_CLK_IN(clk), .SRST_IN(srst), .RESET_POWERDOWN_PIN_N_IN(pin_n),
    .CS_N_IN(cs_n), .SCLK_IN(sclk), .DIN_IN(din), .DOUT_OUT(dout),
    .CMD_CODE_OUT(code), .CMD_STB_OUT(stb), .PRIMARY_RUN_OUT(pri_run),
    .AUXILIARY_RUN_OUT(aux_run), .POWER_DOWN_OUT(pd),
    .DEVICE_RESET_OUT(dev_rst), .RESET_FLAG_OUT(flag),
    .RESET_FLAG_CLR_IN(clr), .REG_ADDR_OUT(addr), .REG_RD_STB_OUT(rd_stb),
    .REG_RDATA_IN(rdata), .REG_WR_STB_OUT(wr_stb), .REG_WDATA_OUT(wdata),
    .CHOP_EN_IN(chop), .SETTLE_DELAY_IN(dly), .PRI_CONV_VALID_IN(pvalid),
    .PRI_CONV_DATA_IN(pdata), .PRI_POLARITY_OUT(pol),
    .PRI_SETTLING_OUT(settling), .PRI_RESULT_VALID_OUT(res_valid),
    .PRI_RESULT_OUT(res), .AUX_CONV_VALID_IN(avalid),
    .AUX_CONV_DATA_IN(adata));
  acr_host_model host (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk),
    .din_out(din), .dout_in(dout));

  // record strobes, results and reset events
  always @(posedge clk) n_stb += int'(stb);
  always @(posedge clk) if (stb) last_cmd = code;
  always @(posedge clk) n_res += int'(res_valid);
  always @(posedge clk) n_rd += int'(rd_stb);
  always @(posedge clk) if (res_valid) last_res = res;
  always @(posedge clk) if (dev_rst === 1'b1) rst_seen = 1'b1;
  always @(posedge clk) if (pd === 1'b1) pd_seen = 1'b1;
  always @(posedge clk)
  begin
    if (wr_stb) wr_log[n_wr[1:0]] = {addr, wdata};
    n_wr += int'(wr_stb);
  end
  // length of the last settling stretch
  always @(posedge clk)
  begin
    if (settling === 1'b1) set_cnt++;
    else if (set_cnt != 0) last_run = set_cnt;
    if (settling !== 1'b1) set_cnt = 0;
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= LIMIT) n_fail++;
    if (cyc >= LIMIT) stop_test();
  end

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    host.select();
    host.xfer(b, rx);
    host.deselect();
  endtask

  task automatic clear_flag();
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    `CHK(flag, 1'b0)
  endtask

  task automatic sample(input logic [PRI_W-1:0] d);
    for (int i = 0; i < 300 && settling !== 1'b0; i++)
      @(negedge clk);
    pdata = d;
    pvalid = 1'b1;
    @(negedge clk);
    pvalid = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // every single-byte opcode except reset, both low-bit values, with both run states checked after each
  task automatic t_decode();
    logic [7:0] op [20] = '{8'h08, 8'h0C, 8'h00, 8'h12, 8'h13, 8'h14,
      8'h15, 8'h16, 8'h17, 8'h19, 8'h1B, 8'h1C, 8'h1E, 8'h0A, 8'h09,
      8'h0E, 8'h0D, 8'h0B, 8'h0F, 8'h00};
    acr_cmd_t ex [20] = '{CMD_PRI_BEGIN, CMD_AUX_BEGIN, CMD_NOP,
      CMD_PRI_READ, CMD_PRI_READ, CMD_AUX_READ, CMD_AUX_READ,
      CMD_PRI_SYS_OFS, CMD_PRI_SYS_GAIN, CMD_PRI_SELF_OFS, CMD_AUX_SYS_OFS,
      CMD_AUX_SYS_GAIN, CMD_AUX_SELF_OFS, CMD_PRI_HALT, CMD_PRI_BEGIN,
      CMD_AUX_HALT, CMD_AUX_BEGIN, CMD_PRI_HALT, CMD_AUX_HALT, CMD_NOP};
    logic pr = 1'b0;
    logic ar = 1'b0;
    int k;
    for (int i = 0; i < 20; i++)
    begin
      k = n_stb;
      if (ex[i] == CMD_PRI_BEGIN || ex[i] == CMD_PRI_HALT) pr = !op[i][1];
      if (ex[i] == CMD_AUX_BEGIN || ex[i] == CMD_AUX_HALT) ar = !op[i][1];
      cmd(op[i]);
      `CHK(n_stb, k + 1)
      `CHK(last_cmd, ex[i])
      `CHK(pri_run, pr)
      `CHK(aux_run, ar)
    end
    $display("test decode done");
  endtask

  // reset command in both forms, with converters running
  task automatic t_rst_cmd();
    for (int i = 6; i < 8; i++)
    begin
      cmd(8'h08);
      cmd(8'h0C);
      clear_flag();
      rst_seen = 1'b0;
      cmd(8'(i));
      `CHK(last_cmd, CMD_RESET)
      `CHK(rst_seen, 1'b1)
      `CHK({pri_run, aux_run}, 2'b00)
      `CHK(flag, 1'b1)
      host.idle(RST_CMD_GAP_CYC);
    end
    $display("test reset command done");
  endtask

  // register write, aborted write, read against a fresh result
  task automatic t_reg();
    n_wr = 0;
    host.select();
    host.xfer(8'h45, rx);
    host.xfer(8'h01, rx);
    host.xfer(8'h3C, rx);
    host.xfer(8'hC3, rx);
    host.deselect();
    `CHK(n_wr, 2)
    `CHK(wr_log[0], {5'h05, 8'h3C})
    `CHK(wr_log[1], {5'h06, 8'hC3})
    host.select();
    host.xfer(8'h45, rx);
    host.xfer(8'h01, rx);
    host.xfer(8'h5A, rx);
    host.deselect();
    cmd(8'h08);
    `CHK(n_wr, 3)
    `CHK(last_cmd, CMD_PRI_BEGIN)
    n_rd = 0;
    host.select();
    host.xfer(8'h25, rx);
    host.xfer(8'h00, rx);
    sample(32'h1234_5678);
    host.xfer(8'h00, rx);
    host.deselect();
    `CHK(rx, 8'hA0)
    `CHK(n_rd, 1)
    host.select();
    host.xfer(8'h12, rx);
    for (int i = 0; i < 4; i++)
    begin
      host.xfer(8'h00, rx);
      word = {word[23:0], rx};
    end
    host.deselect();
    `CHK(word, 32'h1234_5678)
    cmd(8'h0C);
    adata = 24'hA1_B2C3;
    avalid = 1'b1;
    @(negedge clk);
    avalid = 1'b0;
    host.select();
    host.xfer(8'h14, rx);
    for (int i = 0; i < 4; i++)
    begin
      host.xfer(8'h00, rx);
      word = {word[23:0], rx};
    end
    host.deselect();
    `CHK(word, 32'hA1B2_C300)
    cmd(8'h0E);
    cmd(8'h0A);
    $display("test registers done");
  endtask

  // chop: withheld first sample, signed half differences, settling
  task automatic t_chop();
    chop = 1'b1;
    cmd(8'h08);
    n_res = 0;
    `CHK(pol, 1'b0)
    sample(32'd100);
    `CHK(n_res, 0)
    `CHK(pol, 1'b1)
    sample(32'hFFFF_FFEC);
    `CHK(last_res, 32'h0000_003C)
    `CHK(pol, 1'b0)
    sample(32'd90);
    `CHK(last_res, 32'h0000_0037)
    `CHK(last_run, 32)
    pvalid = 1'b1;
    @(negedge clk);
    pvalid = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(n_res, 2)
    cmd(8'h0A);
    chop = 1'b0;
    $display("test chop done");
  endtask

  // pin: shortest reset, pulse just short of power-down, power-down
  task automatic t_pin();
    cmd(8'h0C);
    clear_flag();
    rst_seen = 1'b0;
    pd_seen = 1'b0;
    pin_n = 1'b0;
    repeat (RST_MIN_CYC) @(negedge clk);
    pin_n = 1'b1;
    host.idle(RST_CMD_GAP_CYC);
    `CHK({rst_seen, pd_seen, aux_run, flag}, 4'b1001)
    cmd(8'h08);
    `CHK(last_cmd, CMD_PRI_BEGIN)
    pin_n = 1'b0;
    repeat (PD_SIM - 8) @(negedge clk);
    pin_n = 1'b1;
    host.idle(RST_CMD_GAP_CYC);
    `CHK({pd_seen, pri_run}, 2'b00)
    pin_n = 1'b0;
    repeat (PD_SIM + 8) @(negedge clk);
    `CHK(pd, 1'b1)
    repeat (40) @(negedge clk);
    `CHK({pd, $isunknown(dout)}, 2'b10)
    rst_seen = 1'b0;
    pin_n = 1'b1;
    repeat (8) @(negedge clk);
    `CHK({pd, rst_seen, flag}, 3'b011)
    host.idle(PD_EXIT_GAP_CYC);
    cmd(8'h08);
    `CHK(last_cmd, CMD_PRI_BEGIN)
    $display("test pin done");
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    `CHK({flag, pd, dev_rst}, 3'b100)
    t_decode();
    t_rst_cmd();
    t_reg();
    t_chop();
    t_pin();
    stop_test();
  end
endmodule
`default_nettype wire
